// ===== test/clhp_host_model.sv
// Processor model: strobes transfers on the parallel host port.
// Assumes the bench calls its tasks and clears wide for nibble mode.
module clhp_host_model
(
    // Clock
    input wire logic ref_clk,
    // Port pins
    output clhp_pkg::clhp_host_in_type host_in,
    input wire clhp_pkg::clhp_host_out_type host_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import clhp_pkg::*;
    logic wide;
    initial
    begin
        wide = 1'b1;
        host_in = '0;
    end
    // One strobe; released lines show the inverse of their last value
    task automatic pulse(input clhp_op_type op, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        host_in.register_select <= op[1];
        host_in.read_not_write <= op[0];
        host_in.host_data_lines <= op[0] ? ~host_in.host_data_lines : d;
        host_in.strobe <= 1'b1;
        repeat (3) @(posedge ref_clk);
        q = host_out.data_out;
        host_in.strobe <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic xfer(input clhp_op_type op, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (wide)
            pulse(op, d, q);
        else
        begin
            pulse(op, {d[7:4], ~host_in.host_data_lines[3:0]}, h);
            pulse(op, {d[3:0], ~host_in.host_data_lines[3:0]}, l);
            q = {h[7:4], l[7:4]};
        end
    endtask
    // Bounded busy poll before a transfer
    task automatic poll(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 1000 && !ok; i++)
        begin
            xfer(CLHP_OP_ST_RD, 8'h00, s);
            ok = !s[7];
        end
    endtask
endmodule

// ===== test/clhp_host_port_checker.sv
// Checker: host port bus timing, busy length and scan timing.
// Assumes it is bound to clhp_host_port.
module clhp_host_port_checker
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Watched ports
    input wire clhp_pkg::clhp_host_in_type host_in,
    input wire clhp_pkg::clhp_host_out_type host_out,
    input wire clhp_pkg::clhp_scan_type scan_out,
    input wire logic busy_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    import clhp_pkg::*;
    logic stb_q;
    logic take;
    logic wide_m;
    logic half_m;
    logic [3:0] nib_m;
    logic [7:0] byte_m;
    logic whole;
    logic [4:0] idx_q;
    logic [11:0] busy_q;
    logic [13:0] gap_q;
    logic seen_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    assign take = stb_q && !host_in.strobe && !host_in.register_select
        && !host_in.read_not_write;
    sequence rd_seq;
        host_in.strobe && host_in.read_not_write;
    endsequence
    // Mirror of the byte assembly: a nibble-mode instruction completes on its second strobe
    assign byte_m = wide_m ? host_in.host_data_lines : {nib_m, host_in.host_data_lines[7:4]};
    assign whole = wide_m || half_m;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wide_m <= 1'b1;
            half_m <= 1'b0;
            nib_m <= 4'h0;
        end
        else
        begin
            if (stb_q && !host_in.strobe && !wide_m)
            begin
                half_m <= !half_m;
                nib_m <= host_in.host_data_lines[7:4];
            end
            if (take && whole && !busy_flag && byte_m[7:5] == 3'b001)
                wide_m <= byte_m[4];
        end
    end
    sequence take_seq;
        take && whole && !busy_flag;
    endsequence
    always_ff @(posedge ref_clk)
    begin
        stb_q <= host_in.strobe;
        idx_q <= scan_out.common_index;
    end
    always_ff @(posedge ref_clk)
        busy_q <= (reset_n && busy_flag) ? busy_q + 12'h001 : 12'h000;
    always_ff @(posedge ref_clk)
    begin
        gap_q <= (idx_q != scan_out.common_index) ? 14'h0000 : gap_q + 14'h0001;
        seen_q <= reset_n && !take && (seen_q || idx_q != scan_out.common_index);
    end
    rd_drive_a:
        assert property (rd_seq |=> host_out.data_oe_n[7:4] == 4'h0) else $error("read not driven");
    bus_float_a:
        assert property (!(host_in.strobe && host_in.read_not_write) |=> host_out.data_oe_n == 8'hFF)
        else $error("bus driven outside read");
    rd_stand_a:
        assert property (rd_seq ##1 host_in.strobe |=> $stable(host_out.data_out))
        else $error("read data moved");
    busy_rise_a:
        assert property (take_seq |-> ##[1:8] busy_flag) else $error("busy not raised");
    busy_len_a:
        assert property ($fell(busy_flag) |-> busy_q inside {[12'h168:12'h191], [12'h938:12'h961]})
        else $error("busy length wrong");
    one_common_a:
        assert property ($onehot0(scan_out.common_select)) else $error("several commons");
    scan_gap_a:
        assert property (seen_q && idx_q != scan_out.common_index
            |-> gap_q == 14'h3E7F || gap_q == 14'h1F3F) else $error("common period wrong");
    reset_idle_a:
        assert property ($rose(reset_n) |-> host_out.data_oe_n == 8'hFF && !busy_flag
            && scan_out.common_select == 16'h0000) else $error("not idle after reset");
endmodule
bind clhp_host_port clhp_host_port_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_in(host_in), .host_out(host_out), .scan_out(scan_out), .busy_flag(busy_flag));

// ===== test/clhp_host_port_tb.sv
// Bench for clhp_host_port: register table, nibble mode, busy, scan.
// Assumes the host model and the bound checker.
module clhp_host_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import clhp_pkg::*;
    typedef struct packed
    {
        logic np;
        logic ck;
        clhp_op_type op;
        logic [7:0] din;
        logic [7:0] exp;
    } clhp_row_type;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    clhp_host_in_type host_in;
    clhp_host_out_type host_out;
    clhp_scan_type scan_out;
    logic busy_flag;
    int checked = 0;
    int miscompares = 0;
    clhp_row_type rows [28];
    always #50 ref_clk = ~ref_clk;
    clhp_host_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_in(host_in),
        .host_out(host_out), .scan_out(scan_out), .busy_flag(busy_flag));
    clhp_host_model u_host (.ref_clk(ref_clk), .host_in(host_in), .host_out(host_out));
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reset_dut();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask
    task automatic run_rows(input int a, input int b);
        logic ok;
        logic [7:0] q;
        for (int i = a; i < b; i++)
        begin
            ok = 1'b1;
            if (!rows[i].np)
                u_host.poll(ok);
            if (ok !== 1'b1)
            begin
                miscompares++;
                end_sim();
            end
            u_host.xfer(rows[i].op, rows[i].din, q);
            if (rows[i].ck)
                check(q, rows[i].exp);
            if (rows[i].ck && rows[i].op == CLHP_OP_ST_RD)
                check({1'b0, scan_out.cursor_address}, {1'b0, rows[i].exp[6:0]});
        end
    endtask
    task automatic scan_wait(input int n);
        logic [7:0] hi;
        logic lo;
        hi = 8'h00;
        lo = 1'b0;
        repeat (n)
        begin
            @(negedge ref_clk);
            hi = hi | scan_out.common_select[15:8];
            lo = lo | (|scan_out.common_select);
        end
        check({7'h00, lo}, 8'h01);
        if (n > 20000)
            check(hi, 8'h00);
    endtask
    initial
    begin
        // Fields: no poll, compare, op, write byte, expected byte
        rows = '{20'h08500, 20'h50005, 20'h24100, 20'h50006, 20'h08500, 20'h70041, 20'h50006,
            20'h00400, 20'h24200, 20'h50005, 20'h04200, 20'h21F00, 20'h04200, 20'h7001F,
            20'h00600, 20'h08300, 20'h88900, 20'h50003, 20'h00100, 20'h50000, 20'h00E00,
            20'h02800, 20'h09000, 20'h2A500, 20'h09000, 20'h700A5, 20'h50011, 20'h00C00};
        reset_dut();
        @(negedge ref_clk);
        check(host_out.data_oe_n, 8'hFF);
        check({host_out.data_out[6:0], busy_flag}, 8'h00);
        check(scan_out.common_select[7:0], 8'h00);
        run_rows(0, 21);
        scan_wait(34000);
        check({7'h00, scan_out.cursor_on}, 8'h01);
        reset_dut();
        run_rows(21, 22);
        u_host.wide = 1'b0;
        run_rows(22, 28);
        scan_wait(18000);
        end_sim();
    end
endmodule

// ===== verilog/clhp_host_port.sv
// Character display host port: host register decode, busy flag, address counter, scan timing.
// Assumes host pins are synchronous to ref_clk; strobe is acted on at its falling edge.
`include "clhp_map.svh"
module clhp_host_port
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Host pins
    input wire clhp_pkg::clhp_host_in_type host_in,
    output clhp_pkg::clhp_host_out_type host_out,
    // Display scan and busy flag
    output clhp_pkg::clhp_scan_type scan_out,
    output logic busy_flag
);
    import clhp_pkg::*;

    logic [7:0] display_ram [0:`CLHP_DD_DEPTH-1];
    logic [7:0] glyph_ram [0:`CLHP_CG_DEPTH-1];
    logic strobe_q;
    logic fall;
    logic wide_q;
    logic two_line_q;
    logic tall_font_q;
    logic inc_q;
    logic cg_sel_q;
    logic disp_on_q;
    logic cur_q;
    logic blink_q;
    logic half_q;
    logic [3:0] hold_nib_q;
    logic [6:0] address_counter_q;
    logic [7:0] instruction_reg_q;
    logic [7:0] data_reg_q;
    logic [5:0] busy_cnt_q;
    logic [7:0] byte_in;
    logic byte_done;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic [6:0] step_addr;
    clhp_op_type op;
    logic [5:0] osc_cnt_q;
    logic osc_tick;
    logic [8:0] scan_cnt_q;
    logic [8:0] scan_len;
    logic [4:0] duty;
    logic [4:0] com_q;
    logic frame_q;

    assign fall = strobe_q && !host_in.strobe;
    assign op = clhp_op_type'({host_in.register_select, host_in.read_not_write});
    // Byte assembly: whole byte, or high nibble then low nibble on upper lines
    assign byte_in = wide_q ? host_in.host_data_lines
        : {hold_nib_q, host_in.host_data_lines[7:4]};
    assign byte_done = wide_q || half_q;
    assign status_byte = {busy_flag, address_counter_q};
    assign step_addr = inc_q ? address_counter_q + `CLHP_ADDR_ONE
        : address_counter_q - `CLHP_ADDR_ONE;

    always_comb
    begin
        // Instruction register has no read path
        if (op == CLHP_OP_ST_RD)
        begin
            rd_byte = status_byte;
        end
        else
        begin
            rd_byte = data_reg_q;
        end
    end

    // Strobe edge detect
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            strobe_q <= 1'b0;
        else
            strobe_q <= host_in.strobe;
    end

    // Nibble phase tracking
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            half_q <= 1'b0;
            hold_nib_q <= 4'h0;
        end
        else if (fall && !wide_q)
        begin
            half_q <= !half_q;
            hold_nib_q <= host_in.host_data_lines[7:4];
        end
    end

    // Read drive: busy/address or data register, high nibble first in nibble mode
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            host_out.data_out <= `CLHP_BYTE_ZERO;
            host_out.data_oe_n <= 8'hFF;
        end
        else if (host_in.strobe && host_in.read_not_write)
        begin
            host_out.data_oe_n <= 8'h00;
            if (wide_q)
                host_out.data_out <= rd_byte;
            else if (!half_q)
                host_out.data_out <= {rd_byte[7:4], 4'h0};
            else
                host_out.data_out <= {rd_byte[3:0], 4'h0};
        end
        else
        begin
            host_out.data_oe_n <= 8'hFF;
            host_out.data_out <= `CLHP_BYTE_ZERO;
        end
    end

    // Instruction execution, configuration and address counter
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            instruction_reg_q <= `CLHP_BYTE_ZERO;
            address_counter_q <= `CLHP_ADDR_ZERO;
            busy_cnt_q <= 6'd0;
            busy_flag <= 1'b0;
            wide_q <= 1'b1;
            two_line_q <= 1'b0;
            tall_font_q <= 1'b0;
            inc_q <= 1'b1;
            cg_sel_q <= 1'b0;
            disp_on_q <= 1'b0;
            cur_q <= 1'b0;
            blink_q <= 1'b0;
        end
        else
        begin
            if (busy_cnt_q != 6'd0)
            begin
                if (osc_tick)
                    busy_cnt_q <= busy_cnt_q - 6'd1;
                busy_flag <= 1'b1;
            end
            else
            begin
                busy_flag <= 1'b0;
            end
            if (fall && byte_done)
            begin
                if (op == CLHP_OP_IR_WR && !busy_flag)
                begin
                    instruction_reg_q <= byte_in;
                    busy_cnt_q <= `CLHP_BUSY_CLKS;
                    busy_flag <= 1'b1;
                    if (byte_in[`CLHP_CMD_DDA_BIT])
                    begin
                        address_counter_q <= byte_in[6:0];
                        cg_sel_q <= 1'b0;
                    end
                    else if (byte_in[`CLHP_CMD_CGA_BIT])
                    begin
                        address_counter_q <= byte_in[6:0] & `CLHP_CG_MASK;
                        cg_sel_q <= 1'b1;
                    end
                    else if (byte_in[`CLHP_CMD_FUNC_BIT])
                    begin
                        wide_q <= byte_in[`CLHP_FUNC_WIDE_BIT];
                        two_line_q <= byte_in[`CLHP_FUNC_LINES_BIT];
                        tall_font_q <= byte_in[`CLHP_FUNC_FONT_BIT];
                    end
                    else if (byte_in[`CLHP_CMD_DISP_BIT])
                    begin
                        disp_on_q <= byte_in[`CLHP_DISP_ON_BIT];
                        cur_q <= byte_in[`CLHP_DISP_CUR_BIT];
                        blink_q <= byte_in[`CLHP_DISP_BLINK_BIT];
                    end
                    else if (byte_in[`CLHP_CMD_ENTRY_BIT])
                    begin
                        inc_q <= byte_in[`CLHP_ENTRY_INC_BIT];
                    end
                    else if (byte_in[`CLHP_CMD_HOME_BIT] || byte_in[`CLHP_CMD_CLEAR_BIT])
                    begin
                        address_counter_q <= `CLHP_ADDR_ZERO;
                        cg_sel_q <= 1'b0;
                        inc_q <= byte_in[`CLHP_CMD_CLEAR_BIT] ? 1'b1 : inc_q;
                        busy_cnt_q <= `CLHP_BUSY_LONG;
                    end
                end
                else if (op[1])
                begin
                    address_counter_q <= cg_sel_q ? (step_addr & `CLHP_CG_MASK)
                        : step_addr;
                end
            end
        end
    end

    // Data register and RAM access at the address counter
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            data_reg_q <= `CLHP_BYTE_ZERO;
        else if (fall && byte_done && op == CLHP_OP_DR_WR)
        begin
            data_reg_q <= byte_in;
            if (cg_sel_q)
                glyph_ram[address_counter_q[5:0]] <= byte_in;
            else if (address_counter_q < 7'(`CLHP_DD_DEPTH))
                display_ram[address_counter_q] <= byte_in;
        end
        else if (fall && byte_done && op == CLHP_OP_DR_RD)
        begin
            // Prefetch the byte at the stepped address for the next read
            if (cg_sel_q)
                data_reg_q <= glyph_ram[step_addr[5:0]];
            else if (step_addr < 7'(`CLHP_DD_DEPTH))
                data_reg_q <= display_ram[step_addr];
            else
                data_reg_q <= `CLHP_BLANK;
        end
        else if (busy_flag && instruction_reg_q[7:6] != 2'b00)
        begin
            if (instruction_reg_q[`CLHP_CMD_DDA_BIT])
                data_reg_q <= (address_counter_q < 7'(`CLHP_DD_DEPTH))
                    ? display_ram[address_counter_q] : `CLHP_BLANK;
            else
                data_reg_q <= glyph_ram[address_counter_q[5:0]];
        end
    end

    // Oscillator-rate tick
    assign osc_tick = (osc_cnt_q == `CLHP_OSC_DIV - 6'd1);
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || osc_tick)
            osc_cnt_q <= 6'd0;
        else
            osc_cnt_q <= osc_cnt_q + 6'd1;
    end

    // Duty and scan period from configuration
    assign duty = two_line_q ? `CLHP_DUTY16
        : (tall_font_q ? `CLHP_DUTY11 : `CLHP_DUTY8);
    assign scan_len = two_line_q ? `CLHP_SCAN_SHORT
        : `CLHP_SCAN_LONG;

    // Common scan sequencer
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            scan_cnt_q <= 9'd0;
            com_q <= 5'd0;
            frame_q <= 1'b0;
        end
        else if (osc_tick)
        begin
            if (scan_cnt_q >= scan_len - 9'd1)
            begin
                scan_cnt_q <= 9'd0;
                if (com_q >= duty - 5'd1)
                begin
                    com_q <= 5'd0;
                    frame_q <= !frame_q;
                end
                else
                    com_q <= com_q + 5'd1;
            end
            else
                scan_cnt_q <= scan_cnt_q + 9'd1;
        end
    end

    // Scan outputs: select only active commons, cursor at address counter
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            scan_out <= '0;
        else
        begin
            scan_out.common_select <= disp_on_q ? (16'h0001 << com_q[3:0]) : 16'h0000;
            scan_out.common_index <= com_q;
            scan_out.frame_toggle <= frame_q;
            scan_out.cursor_address <= address_counter_q;
            scan_out.cursor_on <= disp_on_q && cur_q && !cg_sel_q;
            scan_out.blink_on <= disp_on_q && blink_q && !cg_sel_q;
        end
    end
endmodule

// ===== verilog/clhp_map.svh
// Constants for the character display host port: instruction codes, fields, timing.
// Assumes inclusion by the top module only.
`ifndef CLHP_MAP_SVH
`define CLHP_MAP_SVH
`define CLHP_CMD_CLEAR_BIT 0
`define CLHP_CMD_HOME_BIT 1
`define CLHP_CMD_ENTRY_BIT 2
`define CLHP_CMD_DISP_BIT 3
`define CLHP_CMD_FUNC_BIT 5
`define CLHP_CMD_CGA_BIT 6
`define CLHP_CMD_DDA_BIT 7
`define CLHP_ENTRY_INC_BIT 1
`define CLHP_FUNC_WIDE_BIT 4
`define CLHP_FUNC_LINES_BIT 3
`define CLHP_FUNC_FONT_BIT 2
`define CLHP_DISP_ON_BIT 2
`define CLHP_DISP_CUR_BIT 1
`define CLHP_DISP_BLINK_BIT 0
`define CLHP_ADDR_ZERO 7'h00
`define CLHP_ADDR_ONE 7'h01
`define CLHP_CG_MASK 7'h3F
`define CLHP_SCAN_LONG 9'd400
`define CLHP_SCAN_SHORT 9'd200
`define CLHP_DUTY8 5'd8
`define CLHP_DUTY11 5'd11
`define CLHP_DUTY16 5'd16
`define CLHP_OSC_DIV 6'd40
`define CLHP_BUSY_CLKS 6'd10
`define CLHP_BUSY_LONG 6'd60
`define CLHP_DD_DEPTH 80
`define CLHP_CG_DEPTH 64
`define CLHP_BLANK 8'h20
`define CLHP_BYTE_ZERO 8'h00
`endif

// ===== verilog/clhp_pkg.sv
// Types for the character display host port.
// Assumes the map header supplies all numeric constants.
package clhp_pkg;
    typedef enum logic [1:0]
    {
        CLHP_OP_IR_WR = 2'b00,
        CLHP_OP_ST_RD = 2'b01,
        CLHP_OP_DR_WR = 2'b10,
        CLHP_OP_DR_RD = 2'b11
    } clhp_op_type;
    typedef struct packed
    {
        logic strobe;
        logic register_select;
        logic read_not_write;
        logic [7:0] host_data_lines;
    } clhp_host_in_type;
    typedef struct packed
    {
        logic [7:0] data_out;
        logic [7:0] data_oe_n;
    } clhp_host_out_type;
    typedef struct packed
    {
        logic [15:0] common_select;
        logic [4:0] common_index;
        logic frame_toggle;
        logic [6:0] cursor_address;
        logic cursor_on;
        logic blink_on;
    } clhp_scan_type;
endpackage
